// ---- logic/bfc_ctrl.sv ----
// command decoder, embedded operation sequencer and protection for a two-bank flash
`timescale 1ns/1ps
`default_nettype none
`include "bfc_defines.svh"
module bfc_ctrl #(
  parameter bit LARGE_PART = 1'b1,
  parameter int ERASE_CYC = `BFC_ERASE_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // parallel bus pins
  input wire logic chip_enable_n,
  input wire logic write_enable_n,
  input wire logic output_enable_n,
  input wire logic burst_address_load_n,
  input wire logic burst_clock,
  input wire logic [`BFC_ADDR_W-1:0] addr,
  input wire logic [`BFC_DATA_W-1:0] data_in,
  output logic [`BFC_DATA_W-1:0] data_out,
  output logic data_oe,
  // control pins
  input wire logic hw_reset_n,
  input wire logic write_protect_n,
  input wire logic low_supply,
  output logic ready_busy_n,
  output logic sleeping,
  output logic standby,
  // array port
  output logic array_wr,
  output logic array_erase,
  output logic [`BFC_SEC_W-1:0] array_sector,
  output logic [`BFC_ADDR_W-1:0] array_addr,
  output logic [`BFC_DATA_W-1:0] array_wdata,
  input wire logic [`BFC_DATA_W-1:0] array_rdata
);
  import bfc_pkg::*;

  // ======================================
  // pin synchronisers
  logic [7:0] s1_reg, s2_reg, s1_next, s2_next;
  logic [`BFC_ADDR_W-1:0] a1_reg, a2_reg;
  logic [`BFC_DATA_W-1:0] d1_reg, d2_reg;
  logic we_prev_reg;
  logic ce_n, we_n, oe_n, rst_pin_n, wp_n, lowv, adv_n, bclk;
  always_comb begin
    s1_next = {hw_reset_n, write_protect_n, low_supply, burst_address_load_n, burst_clock,
               output_enable_n, write_enable_n, chip_enable_n};
    s2_next = s1_reg;
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s1_reg <= 8'hD7;
      s2_reg <= 8'hD7;
      a1_reg <= '0;
      a2_reg <= '0;
      d1_reg <= '0;
      d2_reg <= '0;
      we_prev_reg <= 1'b1;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      a1_reg <= addr;
      a2_reg <= a1_reg;
      d1_reg <= data_in;
      d2_reg <= d1_reg;
      we_prev_reg <= we_n;
    end
  end
  assign ce_n = s2_reg[0];
  assign we_n = s2_reg[1];
  assign oe_n = s2_reg[2];
  assign bclk = s2_reg[3];
  assign adv_n = s2_reg[4];
  assign lowv = s2_reg[5];
  assign wp_n = s2_reg[6];
  assign rst_pin_n = s2_reg[7];

  // ======================================
  // write strobe: address and data latched on rising write edge
  logic wr_stb;
  logic [7:0] cmd;
  logic [`BFC_SEC_W-1:0] sec_of_addr;
  assign wr_stb = we_n && !we_prev_reg && !ce_n && !lowv && rst_pin_n;
  assign cmd = d2_reg[7:0];
  assign sec_of_addr = a2_reg[`BFC_ADDR_W-1:`BFC_ADDR_W-`BFC_SEC_W];

  // ======================================
  // protection
  logic [`BFC_NUM_SEC-1:0] prot_reg, prot_next;
  bfc_prot_type pmode_reg, pmode_next;
  logic pw_unlocked_reg, pw_unlocked_next;
  logic [`BFC_NUM_SEC-1:0] blocked;
  genvar g;
  generate
    for (g = 0; g < `BFC_NUM_SEC; g++) begin : g_block
      // outer large-bank sectors under write protect
      // protect bits hold in either mode
      assign blocked[g] = (!wp_n && (g == `BFC_WP_SEC_LO || g == `BFC_WP_SEC_HI)) || prot_reg[g];
    end
  endgenerate

  // ======================================
  // command sequencer and embedded operations
  bfc_cmd_type cst_reg, cst_next;
  bfc_op_type op_reg, op_next;
  logic bypass_reg, bypass_next;
  logic [`BFC_CNT_W-1:0] cnt_reg, cnt_next;
  logic [`BFC_CNT_W-1:0] ecnt_reg, ecnt_next;
  logic [`BFC_SEC_W-1:0] op_sec_reg, op_sec_next, es_sec_reg, es_sec_next;
  logic [`BFC_ADDR_W-1:0] op_addr_reg, op_addr_next;
  logic [`BFC_DATA_W-1:0] op_data_reg, op_data_next;
  logic toggle_reg, toggle_next;
  logic secure_reg, secure_next;
  logic bank_of_op, bank_of_addr, in_range;
  assign in_range = LARGE_PART || !a2_reg[`BFC_ADDR_W-1];
  assign bank_of_op = op_sec_reg >= `BFC_BANK_SPLIT;
  assign bank_of_addr = sec_of_addr >= `BFC_BANK_SPLIT;

  always_comb begin
    cst_next = cst_reg;
    op_next = op_reg;
    bypass_next = bypass_reg;
    cnt_next = cnt_reg;
    ecnt_next = ecnt_reg;
    op_sec_next = op_sec_reg;
    es_sec_next = es_sec_reg;
    op_addr_next = op_addr_reg;
    op_data_next = op_data_reg;
    prot_next = prot_reg;
    pmode_next = pmode_reg;
    pw_unlocked_next = pw_unlocked_reg;
    toggle_next = toggle_reg;
    secure_next = secure_reg;
    array_wr = 1'b0;
    array_erase = 1'b0;
    if (op_reg == bfc_programming || op_reg == bfc_erasing) begin
      toggle_next = !toggle_reg;
    end
    if (op_reg == bfc_programming) begin
      if (cnt_reg == '0) begin
        array_wr = 1'b1;
        op_next = (ecnt_reg != '0) ? bfc_suspended : bfc_ready;
      end else begin
        cnt_next = cnt_reg - 1'b1;
      end
    end else if (op_reg == bfc_erasing) begin
      if (ecnt_reg == '0) begin
        array_erase = 1'b1;
        op_next = bfc_ready;
      end else begin
        ecnt_next = ecnt_reg - 1'b1;
      end
    end
    if (wr_stb && in_range) begin
      if (cmd == `BFC_CMD_RESET && op_reg != bfc_programming && op_reg != bfc_erasing) begin
        cst_next = bfc_idle;
        secure_next = 1'b0;
      end else if (op_reg == bfc_erasing && cmd == `BFC_CMD_SUSPEND) begin
        op_next = bfc_suspended;
      end else if (op_reg == bfc_suspended && cmd == `BFC_CMD_RESUME && cst_reg == bfc_idle) begin
        op_next = bfc_erasing;
      end else begin
        unique case (cst_reg)
          bfc_idle: begin
            if (bypass_reg && cmd == `BFC_CMD_PROG) begin
              cst_next = bfc_prog_data;
            end else if (bypass_reg && cmd == `BFC_CMD_BYPASS_EXIT) begin
              bypass_next = 1'b0;
            end else if (cmd == `BFC_UNLOCK1) begin
              cst_next = bfc_unl1;
            end
          end
          bfc_unl1: cst_next = (cmd == `BFC_UNLOCK2) ? bfc_unl2 : bfc_idle;
          bfc_unl2: begin
            cst_next = bfc_idle;
            if (cmd == `BFC_CMD_PROG) begin
              cst_next = bfc_prog_data;
            end else if (cmd == `BFC_CMD_ERASE && op_reg == bfc_ready) begin
              cst_next = bfc_erase_unl0;
            end else if (cmd == `BFC_CMD_BYPASS) begin
              bypass_next = 1'b1;
            end else if (cmd == `BFC_CMD_PW_MODE) begin
              pmode_next = bfc_password;
              pw_unlocked_next = 1'b0;
            end else if (cmd == `BFC_CMD_PW_UNLOCK) begin
              pw_unlocked_next = 1'b1;
            end else if (cmd == `BFC_CMD_SECURE) begin
              secure_next = 1'b1;
            end else if (cmd == `BFC_CMD_PROT_SET || cmd == `BFC_CMD_PROT_CLR) begin
              if (pmode_reg == bfc_persistent || pw_unlocked_reg) begin
                prot_next[sec_of_addr] = (cmd == `BFC_CMD_PROT_SET);
              end
            end
          end
          bfc_prog_data: begin
            cst_next = bfc_idle;
            if (!blocked[sec_of_addr] && (op_reg == bfc_ready ||
                (op_reg == bfc_suspended && sec_of_addr != es_sec_reg))) begin
              op_next = bfc_programming;
              cnt_next = `BFC_CNT_W'(`BFC_PROG_CYC);
              op_addr_next = a2_reg;
              op_data_next = d2_reg;
              op_sec_next = sec_of_addr;
            end
          end
          bfc_erase_unl0: cst_next = (cmd == `BFC_UNLOCK1) ? bfc_erase_unl1 : bfc_idle;
          bfc_erase_unl1: cst_next = (cmd == `BFC_UNLOCK2) ? bfc_erase_cmd : bfc_idle;
          bfc_erase_cmd: begin
            cst_next = bfc_idle;
            if (cmd == `BFC_CMD_SEC_ERASE && !blocked[sec_of_addr]) begin
              op_next = bfc_erasing;
              ecnt_next = `BFC_CNT_W'(ERASE_CYC);
              op_sec_next = sec_of_addr;
              es_sec_next = sec_of_addr;
              op_addr_next = a2_reg;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cst_reg <= bfc_idle;
      op_reg <= bfc_ready;
      bypass_reg <= 1'b0;
      cnt_reg <= '0;
      ecnt_reg <= '0;
      op_sec_reg <= '0;
      es_sec_reg <= '0;
      op_addr_reg <= '0;
      op_data_reg <= '0;
      prot_reg <= '0;
      pmode_reg <= bfc_persistent;
      pw_unlocked_reg <= 1'b0;
      toggle_reg <= 1'b0;
      secure_reg <= 1'b0;
    end else if (!rst_pin_n) begin
      cst_reg <= bfc_idle;
      op_reg <= bfc_ready;
      bypass_reg <= 1'b0;
      cnt_reg <= '0;
      ecnt_reg <= '0;
      toggle_reg <= 1'b0;
      secure_reg <= 1'b0;
    end else begin
      cst_reg <= cst_next;
      op_reg <= op_next;
      bypass_reg <= bypass_next;
      cnt_reg <= cnt_next;
      ecnt_reg <= ecnt_next;
      op_sec_reg <= op_sec_next;
      es_sec_reg <= es_sec_next;
      op_addr_reg <= op_addr_next;
      op_data_reg <= op_data_next;
      prot_reg <= prot_next;
      pmode_reg <= pmode_next;
      pw_unlocked_reg <= pw_unlocked_next;
      toggle_reg <= toggle_next;
      secure_reg <= secure_next;
    end
  end

  // ======================================
  // read path, status and power
  logic busy_here, sel_read;
  logic [`BFC_DATA_W-1:0] dout_reg, dout_next;
  logic [`BFC_CNT_W-1:0] idle_reg, idle_next;
  logic [`BFC_ADDR_W-1:0] last_addr_reg;
  assign busy_here = (op_reg == bfc_programming || op_reg == bfc_erasing) && bank_of_op == bank_of_addr;
  assign sel_read = !ce_n && !oe_n;
  always_comb begin
    dout_next = secure_reg ? {`BFC_SECURE_MARK, a2_reg[`BFC_SECURE_IDX_W-1:0]} : array_rdata;
    if (busy_here) begin
      // polling bit inverted, toggle bit flips
      dout_next = '0;
      dout_next[7] = (op_reg == bfc_programming) ? !op_data_reg[7] : 1'b0;
      dout_next[6] = toggle_reg;
    end
    idle_next = (a2_reg != last_addr_reg || !adv_n || bclk) ? '0 :
                (idle_reg == `BFC_CNT_W'(`BFC_SLEEP_CYC)) ? idle_reg : idle_reg + 1'b1;
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dout_reg <= '0;
      idle_reg <= '0;
      last_addr_reg <= '0;
    end else begin
      dout_reg <= dout_next;
      idle_reg <= idle_next;
      last_addr_reg <= a2_reg;
    end
  end
  assign data_out = dout_reg;
  assign data_oe = sel_read && rst_pin_n;
  assign ready_busy_n = !(op_reg == bfc_programming || op_reg == bfc_erasing);
  assign sleeping = idle_reg == `BFC_CNT_W'(`BFC_SLEEP_CYC) && op_reg != bfc_programming && op_reg != bfc_erasing;
  assign standby = ce_n && rst_pin_n;
  assign array_sector = op_sec_reg;
  assign array_addr = (array_wr || array_erase) ? op_addr_reg : a2_reg;
  assign array_wdata = op_data_reg;
endmodule
`default_nettype wire

// ---- logic/bfc_defines.svh ----
// constants for the burst flash command controller
`ifndef BFC_DEFINES_SVH
`define BFC_DEFINES_SVH
// ======================================
// geometry
`define BFC_ADDR_W 20
`define BFC_DATA_W 32
`define BFC_WORDS_LARGE 1048576
`define BFC_WORDS_SMALL 524288
`define BFC_SEC_W 7
`define BFC_NUM_SEC 128
`define BFC_SEC_SHIFT 13
`define BFC_BANK_SPLIT 7'h60
`define BFC_WP_SEC_LO 7'h00
`define BFC_WP_SEC_HI 7'h5F
`define BFC_SECURE_BYTES 256
`define BFC_SECURE_IDX_W 6
// factory marking of the secured words, arbitrary value
`define BFC_SECURE_MARK 26'h2A5_C3E1
// ======================================
// command codes and unlock pattern (neutral values)
`define BFC_UNLOCK1 8'hAA
`define BFC_UNLOCK2 8'h55
`define BFC_CMD_PROG 8'hA0
`define BFC_CMD_ERASE 8'h80
`define BFC_CMD_SEC_ERASE 8'h30
`define BFC_CMD_BYPASS 8'h20
`define BFC_CMD_BYPASS_EXIT 8'h90
`define BFC_CMD_SUSPEND 8'hB0
`define BFC_CMD_RESUME 8'h31
`define BFC_CMD_RESET 8'hF0
`define BFC_CMD_PW_MODE 8'h60
`define BFC_CMD_PW_UNLOCK 8'h25
`define BFC_CMD_PROT_SET 8'h68
`define BFC_CMD_PROT_CLR 8'h69
`define BFC_CMD_SECURE 8'h77
// ======================================
// timing at 40 mhz
`define BFC_CLK_NS 25
`define BFC_PROG_NS 1000
`define BFC_PROG_CYC ((`BFC_PROG_NS + `BFC_CLK_NS - 1) / `BFC_CLK_NS)
`define BFC_ERASE_NS 100000
`define BFC_ERASE_CYC ((`BFC_ERASE_NS + `BFC_CLK_NS - 1) / `BFC_CLK_NS)
`define BFC_SLEEP_NS 2000
`define BFC_SLEEP_CYC ((`BFC_SLEEP_NS + `BFC_CLK_NS - 1) / `BFC_CLK_NS)
`define BFC_CNT_W 16
`endif

// ---- logic/bfc_pkg.sv ----
// types for the burst flash command controller
package bfc_pkg;
  typedef enum logic [2:0] {
    bfc_idle, bfc_unl1, bfc_unl2, bfc_prog_data, bfc_erase_unl0, bfc_erase_unl1, bfc_erase_unl2, bfc_erase_cmd
  } bfc_cmd_type;
  typedef enum logic [1:0] {
    bfc_ready, bfc_programming, bfc_erasing, bfc_suspended
  } bfc_op_type;
  typedef enum logic {
    bfc_persistent, bfc_password
  } bfc_prot_type;
endpackage

// ---- tb/bfc_ctrl_props.sv ----
// assertions on the flash controller pins
`timescale 1ns/1ps
`default_nettype none
`include "bfc_defines.svh"
module bfc_ctrl_chk (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // pins
  input wire logic chip_enable_n,
  input wire logic output_enable_n,
  input wire logic hw_reset_n,
  input wire logic write_protect_n,
  input wire logic low_supply,
  input wire logic ready_busy_n,
  input wire logic data_oe,
  input wire logic standby,
  // array port
  input wire logic array_wr,
  input wire logic array_erase,
  input wire logic [`BFC_SEC_W-1:0] array_sector
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // ======================================
  // operation steps
  sequence op_start;
    $fell(ready_busy_n);
  endsequence
  sequence op_end;
    array_wr || array_erase || !hw_reset_n;
  endsequence
  a_busy_ends: assert property (op_start |-> ##[1:1000] op_end)
    else $error("busy never ended");
  a_pulse_busy: assert property ((array_wr || array_erase) |-> !ready_busy_n)
    else $error("pulse outside busy");
  a_release_after: assert property ((array_wr || array_erase) |=> ready_busy_n)
    else $error("busy kept after pulse");
  a_wr_single: assert property (array_wr |=> !array_wr)
    else $error("write pulse too long");
  a_wp_block: assert property (!write_protect_n && (array_wr || array_erase)
    |-> !(array_sector inside {`BFC_WP_SEC_LO, `BFC_WP_SEC_HI}))
    else $error("protected sector changed");
  a_low_block: assert property (op_start |-> !low_supply)
    else $error("write taken at low supply");
  a_oe_drive: assert property ((!chip_enable_n && !output_enable_n && hw_reset_n) [*3] |-> data_oe)
    else $error("output not driven");
  a_standby_on: assert property ((chip_enable_n && hw_reset_n) [*3] |-> standby)
    else $error("no standby");
  a_hw_abort: assert property (!hw_reset_n [*4] |-> ready_busy_n && !array_wr && !array_erase)
    else $error("reset did not abort");
endmodule
bind bfc_ctrl bfc_ctrl_chk u_chk (.clock, .rst, .chip_enable_n, .output_enable_n, .hw_reset_n,
  .write_protect_n, .low_supply, .ready_busy_n, .data_oe, .standby, .array_wr, .array_erase, .array_sector);
`default_nettype wire

// ---- tb/bfc_array_model.sv ----
// behavioural flash array behind the controller
`timescale 1ns/1ps
`default_nettype none
`include "bfc_defines.svh"
module bfc_array_model (
  // clock
  input wire logic clock,
  // array port
  input wire logic array_wr,
  input wire logic array_erase,
  input wire logic [`BFC_SEC_W-1:0] array_sector,
  input wire logic [`BFC_ADDR_W-1:0] array_addr,
  input wire logic [`BFC_DATA_W-1:0] array_wdata,
  output logic [`BFC_DATA_W-1:0] array_rdata
);
  logic [31:0] mem [int];
  // ======================================
  // erase clears one sector only
  always @(posedge clock) begin
    if (array_wr)
      mem[array_addr] = array_wdata;
    if (array_erase)
      foreach (mem[a])
        if (a[19:13] == array_sector)
          mem[a] = 32'hFFFF_FFFF;
  end
  // unwritten words read as address pattern
  always @(array_addr or negedge clock)
    array_rdata = mem.exists(array_addr) ? mem[array_addr] : {12'h000, array_addr};
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench for the flash command controller
`timescale 1ns/1ps
`default_nettype none
`include "bfc_defines.svh"
module tb_top;
  logic clock = 0, rst = 1, chip_enable_n = 1, write_enable_n = 1, output_enable_n = 1;
  logic burst_address_load_n = 1, burst_clock = 0, hw_reset_n = 1, write_protect_n = 1, low_supply = 0;
  logic [19:0] addr = 0, array_addr;
  logic [31:0] data_in = 0, data_out, array_wdata, array_rdata;
  logic data_oe, ready_busy_n, sleeping, standby, array_wr, array_erase;
  logic [6:0] array_sector;
  int num_errors = 0, checked = 0;
  always #12.5 clock = ~clock;
  bfc_ctrl #(.ERASE_CYC(40)) DUT (.clock, .rst, .chip_enable_n, .write_enable_n, .output_enable_n,
    .burst_address_load_n, .burst_clock, .addr, .data_in, .data_out, .data_oe, .hw_reset_n,
    .write_protect_n, .low_supply, .ready_busy_n, .sleeping, .standby, .array_wr, .array_erase,
    .array_sector, .array_addr, .array_wdata, .array_rdata);
  bfc_array_model u_arr (.clock, .array_wr, .array_erase, .array_sector, .array_addr, .array_wdata,
    .array_rdata);
  // ======================================
  // bus tasks
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask
  task automatic wr(input logic [19:0] a, input logic [31:0] d);
    step(1);
    chip_enable_n = 0; addr = a; data_in = d; write_enable_n = 0;
    step(4);
    write_enable_n = 1;
    step(4);
    chip_enable_n = 1;
  endtask
  task automatic rd(input logic [19:0] a, output logic [31:0] v);
    step(1);
    addr = a; chip_enable_n = 0; output_enable_n = 0;
    step(6);
    v = data_out; output_enable_n = 1; chip_enable_n = 1;
  endtask
  task automatic cmd(input logic [19:0] a, input logic [7:0] c);
    wr(0, 32'(`BFC_UNLOCK1)); wr(0, 32'(`BFC_UNLOCK2)); wr(a, 32'(c));
  endtask
  task automatic prog(input logic [19:0] a, input logic [31:0] d);
    cmd(0, `BFC_CMD_PROG); wr(a, d);
  endtask
  task automatic erase(input logic [19:0] a);
    cmd(0, `BFC_CMD_ERASE); cmd(a, `BFC_CMD_SEC_ERASE);
  endtask
  // bounded wait; a pulse is seen in its own cycle
  task automatic wait_op(input int n, output logic hit);
    hit = 0;
    repeat (n) begin
      @(posedge clock); #2;
      if (array_wr || array_erase) begin hit = 1; break; end
    end
  endtask
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ======================================
  // scenarios
  task automatic t_prog;
    logic [31:0] v1, v2; logic hit;
    prog(20'h0_0010, 32'h1234_5678);
    check(32'(ready_busy_n), 0);
    rd(20'h0_0010, v1); rd(20'h0_0010, v2);
    check(32'(v1[7]), 1);
    check(32'(v1[6] ^ v2[6]), 1);
    wait_op(80, hit);
    check(32'(array_wr), 1);
    check(32'(array_addr), 32'h0_0010);
    check(array_wdata, 32'h1234_5678);
    step(1);
    check(32'(ready_busy_n), 1);
    rd(20'h0_0010, v1);
    check(v1, 32'h1234_5678);
  endtask
  task automatic t_bank_erase;
    logic [31:0] v; logic hit;
    prog(20'hD_0000, 32'hCAFE_0001);
    rd(20'h0_0010, v);
    check(v, 32'h1234_5678);
    wait_op(80, hit);
    erase(20'hD_0000);
    wait_op(80, hit);
    check(32'(array_erase), 1);
    check(32'(array_sector), 32'h68);
    rd(20'hD_0000, v);
    check(v, 32'hFFFF_FFFF);
    rd(20'h0_0010, v);
    check(v, 32'h1234_5678);
  endtask
  task automatic t_prot;
    logic [19:0] a [4] = '{20'h0_0100, 20'hB_E000, 20'h4_0000, 20'h0_0020};
    logic hit;
    cmd(20'h4_0000, `BFC_CMD_PROT_SET);
    cmd(0, `BFC_CMD_PW_MODE);
    for (int i = 0; i < 4; i++) begin
      write_protect_n = (i > 1); low_supply = (i == 3);
      prog(a[i], 32'h0000_00AA);
      wait_op(80, hit);
      check(32'(hit), 0);
    end
    write_protect_n = 1; low_supply = 0;
    cmd(0, `BFC_CMD_PW_UNLOCK);
    cmd(20'h4_0000, `BFC_CMD_PROT_CLR);
    prog(20'h4_0000, 32'h0000_5A5A);
    wait_op(80, hit);
    check(32'(hit), 1);
  endtask
  task automatic t_bypass;
    logic [31:0] v; logic hit;
    cmd(0, `BFC_CMD_BYPASS);
    for (int i = 0; i < 2; i++) begin
      wr(0, 32'(`BFC_CMD_PROG)); wr(20'h0_0040 + 20'(i), 32'h0BAD_0000 + 32'(i));
      wait_op(80, hit);
      check(32'(hit), 1);
      check(array_wdata, 32'h0BAD_0000 + 32'(i));
    end
    wr(0, 32'(`BFC_CMD_BYPASS_EXIT));
    cmd(0, `BFC_CMD_SECURE);
    rd(20'h0_0005, v);
    check(v, {`BFC_SECURE_MARK, 6'h05});
    wr(0, 32'(`BFC_CMD_RESET));
    rd(20'h0_0010, v);
    check(v, 32'h1234_5678);
  endtask
  task automatic t_reset_power;
    logic [31:0] v; logic hit;
    erase(20'h0_A000);
    hw_reset_n = 0;
    step(6);
    check(32'(ready_busy_n), 1);
    hw_reset_n = 1;
    wait_op(60, hit);
    check(32'(hit), 0);
    rd(20'h0_0010, v);
    check(v, 32'h1234_5678);
    step(4);
    check(32'(standby), 1);
    addr = 20'h0_0123;
    step(100);
    check(32'(sleeping), 1);
    addr = 20'h0_0124;
    step(4);
    check(32'(sleeping), 0);
  endtask
  // ======================================
  // main sequence and watchdog
  initial begin
    step(16);
    rst = 0;
    step(4);
    t_prog; t_bank_erase; t_prot; t_bypass; t_reset_power;
    end_of_test;
  end
  // hang guard, well past the expected run
  initial begin
    #1_000_000;
    num_errors++;
    end_of_test;
  end
endmodule
`default_nettype wire
